// ===== logic/spsd_pair_buffer.sv
/*
 * Small FIFO with valid/ready on both sides, two entries by default.
 * Assumes one clock, a synchronous active-high reset and a clock enable.
 */
`timescale 1ns/1ps
module spsd_pair_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // Clock and control
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             ce,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem      [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic [PW-1:0]    next_wr_ptr;
    logic [PW-1:0]    next_rd_ptr;
    logic [CW-1:0]    next_count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != CW'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        next_mem    = mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (push) begin
            next_mem[wr_ptr] = in_data;
            next_wr_ptr      = (wr_ptr == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr + 1'b1);
        end
        if (pop) begin
            next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr + 1'b1);
        end
        if (push && !pop) begin
            next_count = CW'(count + 1'b1);
        end else if (pop && !push) begin
            next_count = CW'(count - 1'b1);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else if (ce) begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
            mem    <= next_mem;
        end
    end
endmodule

// ===== logic/spsd_pkg.sv
/*
 * Constants shared by the serial-to-parallel sink driver and its buffer.
 * Assumes a consumer that imports the whole package.
 */
package spsd_pkg;
    // Data path
    localparam int         SPSD_WIDTH      = 8;
    localparam int         SPSD_GRAY_W     = 3;
    localparam int         SPSD_BUF_DEPTH  = 2;
    localparam int         SPSD_SYNC_W     = 3;
    // Bit positions inside the control synchroniser
    localparam int         SPSD_CTL_CLEAR  = 0;
    localparam int         SPSD_CTL_LOAD   = 1;
    localparam int         SPSD_CTL_OE     = 2;
    // Reset, idle and step values
    localparam logic [7:0] SPSD_ZERO_WORD  = 8'h00;
    localparam logic [2:0] SPSD_GRAY_RESET = 3'h0;
    localparam logic [2:0] SPSD_CTL_RESET  = 3'h4;
    localparam logic [2:0] SPSD_GRAY_STEP  = 3'h1;
    localparam logic       SPSD_OE_IDLE    = 1'h1;
    localparam logic       SPSD_BIT_ZERO   = 1'h0;
endpackage

// ===== logic/spsd_sink_driver.sv
/*
 * Serial-in shift register, storage register and gated sink outputs.
 * Assumes shift_clock is the link clock, all other link pins asynchronous to clk,
 * and the controller idles shift_clock before pulsing storage_load_clock.
 */
// Operation
// [R1] Eight stages shift one bit per clock
// [R2] Storage register loads from parallel stages
// [R3] Shift and storage use separate clocks
// [R4] Cascade output updates each rising shift edge
// [R5] Clear low zeroes stages, storage untouched
// [R6] Storage transfer only while clear high
// [R7] Enable high forces all outputs low
// [R8] Enable low: outputs follow storage bits
// [R9] High bit sinks current, low bit off
// [R10] Board chains cascade output to next input
// [R11] Sample on rising edges, data away
`timescale 1ns/1ps
module spsd_sink_driver #(
    parameter int WIDTH = spsd_pkg::SPSD_WIDTH
) (
    // System clock domain
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             ce,
    // Link pins
    input  wire logic             shift_clock,
    input  wire logic             serial_data_in,
    input  wire logic             shift_clear_n,
    input  wire logic             storage_load_clock,
    input  wire logic             out_enable_n,
    // Outputs
    output logic                  cascade_serial_out,
    output logic [WIDTH-1:0]      sink_on
);
    import spsd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Link domain: shift stages and edge counter
    logic [WIDTH-1:0]       stages;
    logic [WIDTH-1:0]       next_stages;
    logic                   next_cascade;
    logic [SPSD_GRAY_W-1:0] edge_bin;
    logic [SPSD_GRAY_W-1:0] next_edge_bin;
    logic [SPSD_GRAY_W-1:0] edge_gray;
    logic [SPSD_GRAY_W-1:0] next_edge_gray;
    logic                   armed;
    logic                   next_armed;

    always_comb begin
        next_stages    = {stages[WIDTH-2:0], serial_data_in};     // [R1] [R11]
        next_cascade   = next_stages[WIDTH-1];                    // [R4]
        next_edge_bin  = SPSD_GRAY_W'(edge_bin + SPSD_GRAY_STEP);
        next_edge_gray = next_edge_bin ^ (next_edge_bin >> 1);
        // Set by any shift edge since the last clear; chk_shift_advance and chk_gray_step skip the first
        next_armed     = 1'b1;
    end

    // Clear acts without a shift edge, since the link clock may stand still
    always_ff @(posedge shift_clock or negedge shift_clear_n) begin
        if (!shift_clear_n) begin                                 // [R5]
            stages             <= '0;
            cascade_serial_out <= SPSD_BIT_ZERO;
            edge_bin           <= SPSD_GRAY_RESET;
            edge_gray          <= SPSD_GRAY_RESET;
            armed              <= SPSD_BIT_ZERO;
        end else begin                                            // [R3]
            stages             <= next_stages;
            cascade_serial_out <= next_cascade;
            edge_bin           <= next_edge_bin;
            edge_gray          <= next_edge_gray;
            armed              <= next_armed;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // System domain: synchronisers
    logic [SPSD_GRAY_W-1:0] gray_s1;
    logic [SPSD_GRAY_W-1:0] gray_s2;
    logic [SPSD_GRAY_W-1:0] gray_seen;
    logic [SPSD_SYNC_W-1:0] ctl_s1;
    logic [SPSD_SYNC_W-1:0] ctl_s2;
    logic                   load_s3;
    logic [SPSD_GRAY_W-1:0] next_gray_seen;
    logic                   clear_ok;
    logic                   load_edge;
    logic                   outputs_off;

    assign clear_ok    = ctl_s2[SPSD_CTL_CLEAR];
    assign load_edge   = ctl_s2[SPSD_CTL_LOAD] & ~load_s3;
    assign outputs_off = ctl_s2[SPSD_CTL_OE];

    always_ff @(posedge clk) begin
        if (reset) begin
            gray_s1 <= SPSD_GRAY_RESET;
            gray_s2 <= SPSD_GRAY_RESET;
            ctl_s1  <= SPSD_CTL_RESET;
            ctl_s2  <= SPSD_CTL_RESET;
            load_s3 <= SPSD_BIT_ZERO;
        end else if (ce) begin
            gray_s1 <= edge_gray;
            gray_s2 <= gray_s1;
            ctl_s1  <= {out_enable_n, storage_load_clock, shift_clear_n};
            ctl_s2  <= ctl_s1;
            load_s3 <= ctl_s2[SPSD_CTL_LOAD];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Word capture into the buffer
    logic                   buf_in_ready;
    logic                   buf_out_valid;
    logic                   buf_out_ready;
    logic [WIDTH-1:0]       buf_out_data;
    logic                   capture;

    // Gray count survives skipped samples; stages settled by the time it shows
    assign capture       = (gray_s2 != gray_seen);
    // Drain pauses on a load so storage sees a settled word
    assign buf_out_ready = ~load_edge;

    always_comb begin
        next_gray_seen = gray_seen;
        if (capture && buf_in_ready) begin
            next_gray_seen = gray_s2;
        end
    end

    spsd_pair_buffer #(
        .WIDTH (WIDTH),
        .DEPTH (SPSD_BUF_DEPTH)
    ) u_buffer (
        .clk       (clk),
        .reset     (reset),
        .ce        (ce),
        .in_valid  (capture),
        .in_ready  (buf_in_ready),
        .in_data   (stages),
        .out_valid (buf_out_valid),
        .out_ready (buf_out_ready),
        .out_data  (buf_out_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Parallel view, storage register and output buffer
    logic [WIDTH-1:0]       shadow;
    logic [WIDTH-1:0]       next_shadow;
    logic [WIDTH-1:0]       storage;
    logic [WIDTH-1:0]       next_storage;
    logic [WIDTH-1:0]       next_sink_on;

    always_comb begin
        next_shadow  = shadow;
        next_storage = storage;
        if (!clear_ok) begin
            next_shadow = '0;                                     // [R5]
        end else if (buf_out_valid && buf_out_ready) begin
            next_shadow = buf_out_data;                           // [R1]
        end
        if (load_edge && clear_ok) begin                          // [R3] [R6]
            next_storage = shadow;                                // [R2]
        end
        // Registered from next storage, so outputs move with storage
        if (outputs_off) begin
            next_sink_on = '0;                                    // [R7]
        end else begin
            next_sink_on = next_storage;                          // [R8] [R9]
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            gray_seen <= SPSD_GRAY_RESET;
            shadow    <= '0;
            storage   <= '0;
            sink_on   <= '0;
        end else if (ce) begin
            gray_seen <= next_gray_seen;
            shadow    <= next_shadow;
            storage   <= next_storage;
            sink_on   <= next_sink_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_load_taken;
        ce && load_edge && clear_ok;
    endsequence

    sequence s_enabled;
        ce && !outputs_off;
    endsequence

    chk_shift_advance: assert property ( // [R1]
        @(posedge shift_clock) disable iff (!shift_clear_n)
        armed |-> stages == {$past(stages[WIDTH-2:0]), $past(serial_data_in)})
        else $error("shift stages did not advance by one bit");

    chk_cascade_last: assert property ( // [R4]
        @(posedge shift_clock) disable iff (!shift_clear_n)
        cascade_serial_out == stages[WIDTH-1])
        else $error("cascade output is not the last stage");

    chk_clear_zero: assert property ( // [R5]
        @(posedge clk) disable iff (reset)
        (ce && !clear_ok) |=> (shadow == '0) && $stable(storage))
        else $error("clear did not zero stages or touched storage");

    chk_load_gated: assert property ( // [R6]
        @(posedge clk) disable iff (reset)
        (ce && load_edge && !clear_ok) |=> $stable(storage))
        else $error("storage loaded while clear was low");

    chk_load_takes: assert property ( // [R2]
        @(posedge clk) disable iff (reset)
        s_load_taken |=> storage == $past(shadow))
        else $error("storage did not take the parallel word");

    chk_storage_hold: assert property ( // [R3]
        @(posedge clk) disable iff (reset)
        !load_edge |=> $stable(storage))
        else $error("storage changed without a load edge");

    chk_outputs_off: assert property ( // [R7]
        @(posedge clk) disable iff (reset)
        (ce && outputs_off) |=> sink_on == '0)
        else $error("outputs not forced off while disabled");

    chk_outputs_follow: assert property ( // [R8]
        @(posedge clk) disable iff (reset)
        s_enabled |=> sink_on == storage)
        else $error("enabled outputs do not follow storage");

    chk_load_to_sink: assert property ( // [R9]
        @(posedge clk) disable iff (reset)
        (s_load_taken and s_enabled) |=> sink_on == $past(shadow))
        else $error("sink outputs missed the loaded word");

    chk_gray_step: assert property ( // [R11]
        @(posedge shift_clock) disable iff (!shift_clear_n)
        armed |-> $countones(edge_gray ^ $past(edge_gray)) == 1)
        else $error("edge counter moved by more than one code");
endmodule

// ===== sim/spsd_ctrl_model.sv
/*
 * Controller model: drives the link clock and serial data.
 * Assumes the bench calls send_word; link clock idles low between frames.
 */
`timescale 1ns/1ps
module spsd_ctrl_model (
    // Link pins
    output logic shift_clock,
    output logic serial_data_in
);
    initial begin
        shift_clock = 1'b0;
        serial_data_in = 1'b0;
    end
    // Data moves only while the clock is low, away from the rise
    // Gap only delays the frame start; the link period stays 6 ns
    task automatic send_word(input logic [7:0] w, input int gap);
        #gap;
        for (int i = 7; i >= 0; i--) begin
            serial_data_in = w[i];
            #3;
            shift_clock = 1'b1;
            #3;
            shift_clock = 1'b0;
        end
        serial_data_in = ~w[0];
    endtask
endmodule

// ===== sim/spsd_sink_driver_bench.sv
/*
 * Bench for the sink driver; its word buffer is reached through the top only.
 * Assumes the controller model for the link pins.
 */
`timescale 1ns/1ps
module spsd_sink_driver_bench;
    import spsd_pkg::*;
    logic       clk                = 1'b0;
    logic       reset              = 1'b1;
    logic       ce                 = 1'b1;
    logic       shift_clock;
    logic       serial_data_in;
    logic       shift_clear_n      = 1'b1;
    logic       storage_load_clock = 1'b0;
    logic       out_enable_n       = 1'b1;
    logic       cascade_serial_out;
    logic [7:0] sink_on;
    logic [7:0] stored             = 8'h00;
    logic [7:0] w;
    logic [7:0] w_first;
    logic [7:0] chain;
    int         seed               = 36;
    int         n_errors           = 0;
    int         n_checks           = 0;

    spsd_ctrl_model i_spsd_ctrl_model (.shift_clock(shift_clock), .serial_data_in(serial_data_in));
    spsd_sink_driver i_spsd_sink_driver (.clk(clk), .reset(reset), .ce(ce), .shift_clock(shift_clock),
        .serial_data_in(serial_data_in), .shift_clear_n(shift_clear_n),
        .storage_load_clock(storage_load_clock), .out_enable_n(out_enable_n),
        .cascade_serial_out(cascade_serial_out), .sink_on(sink_on));

    // Next device in a chain: its stages are fed by the cascade output
    always @(posedge shift_clock) begin
        chain <= {chain[6:0], cascade_serial_out};
    end

    always #4 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] expect_out(input logic [7:0] st, input logic oe_n);
        return oe_n ? 8'h00 : st;
    endfunction
    // Pin held high 3 cycles and low 6 cycles, longer than the sync needs
    task automatic load();
        @(posedge clk);
        storage_load_clock <= 1'b1;
        cyc(3);
        storage_load_clock <= 1'b0;
        cyc(6);
    endtask
    task automatic conclude();
        if (n_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        // Clear is the link stages' only reset; lifted well before the first shift edge
        shift_clear_n <= 1'b0;
        cyc(2);
        shift_clear_n <= 1'b1;
        cyc(1);
        reset <= 1'b0;
        out_enable_n <= 1'b0;
        for (int k = 0; k < 6; k++) begin
            w = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($random(seed));
            i_spsd_ctrl_model.send_word(w, k % 3);
            chk({7'h00, cascade_serial_out}, {7'h00, w[7]});
            cyc(10);
            chk(sink_on, expect_out(stored, 1'b0));
            load();
            stored = w;
            chk(sink_on, expect_out(stored, 1'b0));
        end
        @(posedge clk);
        out_enable_n <= 1'b1;
        cyc(4);
        chk(sink_on, expect_out(stored, 1'b1));
        out_enable_n <= 1'b0;
        cyc(4);
        chk(sink_on, expect_out(stored, 1'b0));
        i_spsd_ctrl_model.send_word(8'h80, 0);
        @(posedge clk);
        shift_clear_n <= 1'b0;
        cyc(1);
        #1;
        chk({7'h00, cascade_serial_out}, 8'h00);
        load();
        chk(sink_on, expect_out(stored, 1'b0));
        shift_clear_n <= 1'b1;
        cyc(4);
        load();
        chk(sink_on, 8'h00);
        // Two words back to back keep the buffer busy; the chained device holds the first
        w_first = 8'($random(seed));
        w = 8'($random(seed));
        i_spsd_ctrl_model.send_word(w_first, 0);
        i_spsd_ctrl_model.send_word(w, 0);
        chk(chain, w_first);
        chk({7'h00, cascade_serial_out}, {7'h00, w[7]});
        cyc(10);
        load();
        stored = w;
        chk(sink_on, expect_out(stored, 1'b0));
        // Enable low freezes the synchronisers, so the outputs keep their word
        ce <= 1'b0;
        out_enable_n <= 1'b1;
        cyc(4);
        chk(sink_on, expect_out(stored, 1'b0));
        ce <= 1'b1;
        cyc(4);
        chk(sink_on, expect_out(stored, 1'b1));
        conclude();
    end
    initial begin
        #200000;
        n_errors++;
        conclude();
    end
endmodule
